// ### include/fbcw_defs.svh
/*
  Constants of the fieldbus control word interpreter: bit positions,
  mode codes, reset values and watchdog timing.
  Assumes inclusion by bare name from the package and the testbench files.
*/
`ifndef FBCW_DEFS_SVH
`define FBCW_DEFS_SVH

// ==========================================================
// Mode codes
`define FBCW_MODE_PROFILE     2'h1
`define FBCW_MODE_BYPASS      2'h2
`define FBCW_SM_BASIC         2'h1
`define FBCW_SM_PROFILE       2'h2
`define FBCW_PLACE_FIELDBUS   2'h3

// ==========================================================
// Command word bit positions
`define FBCW_CB_ON            0
`define FBCW_CB_COAST_N       1
`define FBCW_CB_QSTOP_N       2
`define FBCW_CB_RUN           3
`define FBCW_CB_RAMP_OUT      4
`define FBCW_CB_RAMP_HOLD_N   5
`define FBCW_CB_RAMP_IN       6
`define FBCW_CB_FAULT_RST     7
`define FBCW_CB_INCH1         8
`define FBCW_CB_INCH2         9
`define FBCW_CB_BUS_CTRL      10
`define FBCW_CB_WDOG          11

// ==========================================================
// Status word bit positions
`define FBCW_SB_READY_ON      0
`define FBCW_SB_READY_OP      1
`define FBCW_SB_RUNNING       2
`define FBCW_SB_FAULT         3
`define FBCW_SB_NO_COAST      4
`define FBCW_SB_NO_QSTOP      5
`define FBCW_SB_INHIBIT       6
`define FBCW_SB_WARNING       7
`define FBCW_SB_AT_REF        8
`define FBCW_SB_BUS_ACTIVE    9
`define FBCW_SB_ABOVE_LIM     10
`define FBCW_SB_DRV_RUN       12
`define FBCW_SB_DRV_READY     13
`define FBCW_SB_WD_ECHO       15

// ==========================================================
// Reset values and timing
`define FBCW_WORD_RESET       16'h0000
`define FBCW_CLK_HZ           40000000
`define FBCW_WD_UNIT_MS       100
`define FBCW_WD_UNIT_CYCLES   ((`FBCW_CLK_HZ / 1000) * `FBCW_WD_UNIT_MS)
`define FBCW_STATUS_SEL_PROF  2'h0
`define FBCW_STATUS_SEL_RAW   2'h1
`define FBCW_STATUS_SEL_ZERO  2'h2

`endif

// ### include/fbcw_pkg.sv
/*
  Types of the fieldbus control word interpreter.
  Assumes fbcw_defs.svh on the include path.
*/
`include "fbcw_defs.svh"

package fbcw_pkg;

  // ==========================================================
  // Operating combination
  typedef enum logic [3:0] {
    COMB_BASIC   = 4'h1,
    COMB_PROFILE = 4'h2,
    COMB_THREE   = 4'h4,
    COMB_REFUSED = 4'h8
  } fbcw_comb_type;

  // ==========================================================
  // Profile state machine
  typedef enum logic [4:0] {
    ST_INHIBIT = 5'h01,
    ST_READY   = 5'h02,
    ST_OPERATE = 5'h04,
    ST_RUN     = 5'h08,
    ST_FAULT   = 5'h10
  } fbcw_state_type;

endpackage : fbcw_pkg

// ### logic/fbcw_edge_sync.sv
/*
  Three-stage synchroniser with agreement filter for pin-side levels.
  Assumes one clock core_clk and synchronous active-low reset rstn.
*/
`timescale 1ns/1ps

module fbcw_edge_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         core_clk,
  input  wire logic         rstn,
  // Level in and out
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] out;
  } fbcw_sync_type;

  fbcw_sync_type r_q;
  fbcw_sync_type r_d;

  // ==========================================================
  // Stages; a bit changes once stages two and three agree
  always_comb begin
    r_d     = r_q;
    r_d.s1  = async_in;
    r_d.s2  = r_q.s1;
    r_d.s3  = r_q.s2;
    for (int i = 0; i < W; i++) begin
      if (r_q.s2[i] == r_q.s3[i]) begin
        r_d.out[i] = r_q.s3[i];
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      r_q <= '0;
    end else begin
      r_q <= r_d;
    end
  end

  assign sync_out = r_q.out;

endmodule : fbcw_edge_sync

// ### logic/fbcw_interp.sv
/*
  Fieldbus control word interpreter and status word builder for a drive.
  Assumes bus words and drive flags arrive asynchronously and are
  synchronised here; one 40 MHz clock, synchronous active-low reset.
*/
// Function
// - Refuse bus operation when board mode and state machine are both profile.
// - Bypass with profile state machine decodes the profile command meanings.
// - Bypass with basic state machine uses the three-bit command scheme.
// - Bypass status word chosen by a parameter, defaulting to profile status.
// - Basic: rising edge of command bit 7 resets faults.
// - Basic: status bit 8 set when actual equals reference.
// - Basic: status bits from board state machine and drive flags.
// - Profile: rising edge of bit 0 leaves inhibit for ready.
// - Profile: bit 1 low commands a coasting stop.
// - Profile: bit 2 low commands a quick stop.
// - Profile: bit 4 low forces ramp output to zero.
// - Profile: bit 5 low holds the ramp output.
// - Profile: bit 6 low forces ramp input to zero.
// - Profile: bits 8 and 9 run at their inching speeds.
// - Bit 10 enables bus control only when control place is fieldbus.
// - Missing bit 11 toggling raises a communication fault.
// - Watchdog not monitored while its delay setting is zero.
// - Ramp output zero outranks ramp hold and ramp input zero.
`timescale 1ns/1ps

module fbcw_interp (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        rstn,
  // Configuration
  input  wire logic [1:0]  bus_board_operate_mode,
  input  wire logic [1:0]  drive_state_machine_select,
  input  wire logic [1:0]  control_place_select,
  input  wire logic [1:0]  profile_status_word_param,
  input  wire logic [7:0]  watchdog_delay_setting,
  // Bus command words and board state machine word
  input  wire logic [15:0] basic_bus_command_word,
  input  wire logic [15:0] profile_bus_command_word,
  input  wire logic [10:0] bus_board_state_machine,
  // Drive flags
  input  wire logic        drv_fault,
  input  wire logic        drv_warning,
  input  wire logic        drv_running,
  input  wire logic        drv_ready,
  input  wire logic        drv_at_ref,
  input  wire logic        drv_above_limit,
  // Status word
  output logic      [15:0] basic_bus_status_word,
  // Drive commands
  output logic             bus_refused,
  output logic             bus_ctrl_active,
  output logic             run_cmd,
  output logic             coast_stop,
  output logic             quick_stop,
  output logic             ramp_out_zero,
  output logic             ramp_hold,
  output logic             ramp_in_zero,
  output logic             inch1_cmd,
  output logic             inch2_cmd,
  output logic             fault_reset,
  output logic             comm_fault,
  output logic             three_bit_mode
);

  // ==========================================================
  // Synchronised inputs
  localparam int SW = 16 + 16 + 11 + 6;
  logic [SW-1:0] sync_v;
  logic [15:0]   bw;
  logic [15:0]   pw;
  logic [10:0]   sm;
  logic [5:0]    df;

  fbcw_edge_sync #(.W(SW)) u_sync (
    .core_clk (core_clk),
    .rstn     (rstn),
    .async_in ({basic_bus_command_word, profile_bus_command_word,
                bus_board_state_machine, drv_fault, drv_warning,
                drv_running, drv_ready, drv_at_ref, drv_above_limit}),
    .sync_out (sync_v)
  );

  assign bw = sync_v[48:33];
  assign pw = sync_v[32:17];
  assign sm = sync_v[16:6];
  assign df = sync_v[5:0];

  // ==========================================================
  // Combination decoding
  function automatic fbcw_pkg::fbcw_comb_type comb_of(input logic [1:0] om,
                                                      input logic [1:0] ss);
    if (om == `FBCW_MODE_PROFILE && ss == `FBCW_SM_PROFILE) begin
      comb_of = fbcw_pkg::COMB_REFUSED;
    end else if (om == `FBCW_MODE_BYPASS && ss == `FBCW_SM_PROFILE) begin
      comb_of = fbcw_pkg::COMB_PROFILE;
    end else if (om == `FBCW_MODE_BYPASS && ss == `FBCW_SM_BASIC) begin
      comb_of = fbcw_pkg::COMB_THREE;
    end else begin
      comb_of = fbcw_pkg::COMB_BASIC;
    end
  endfunction : comb_of

  // ==========================================================
  // State
  typedef struct packed {
    fbcw_pkg::fbcw_state_type st;
    logic [15:0]              bw_prev;
    logic [15:0]              pw_prev;
    logic [22:0]              unit_cnt;
    logic [7:0]               wd_units;
    logic [15:0]              status;
    logic                     refused;
    logic                     active;
    logic                     run;
    logic                     coast;
    logic                     qstop;
    logic                     rout0;
    logic                     rhold;
    logic                     rin0;
    logic                     inch1;
    logic                     inch2;
    logic                     frst;
    logic                     cfault;
    logic                     three;
  } fbcw_core_type;

  fbcw_core_type r_q;
  fbcw_core_type r_d;

  fbcw_pkg::fbcw_comb_type comb;
  logic [15:0]             cw;
  logic [15:0]             prof_status;
  logic [15:0]             cw_prev;
  logic                    wd_edge;

  assign comb = comb_of(bus_board_operate_mode, drive_state_machine_select);
  assign cw   = (comb == fbcw_pkg::COMB_BASIC) ? bw : pw;
  assign cw_prev = (comb == fbcw_pkg::COMB_BASIC) ? r_q.bw_prev : r_q.pw_prev;
  assign wd_edge = cw[`FBCW_CB_WDOG] ^ cw_prev[`FBCW_CB_WDOG];

  // ==========================================================
  // Next state
  always_comb begin
    r_d         = r_q;
    r_d.bw_prev = bw;
    r_d.pw_prev = pw;
    r_d.frst    = 1'b0;
    r_d.refused = (comb == fbcw_pkg::COMB_REFUSED);
    r_d.three   = (comb == fbcw_pkg::COMB_THREE);
    r_d.active  = cw[`FBCW_CB_BUS_CTRL] &&
                  (control_place_select == `FBCW_PLACE_FIELDBUS) &&
                  (comb != fbcw_pkg::COMB_REFUSED);
    // Fault reset on rising edge of bit 7; a new watchdog fault wins
    if (cw[`FBCW_CB_FAULT_RST] && !cw_prev[`FBCW_CB_FAULT_RST] &&
        comb != fbcw_pkg::COMB_REFUSED) begin
      r_d.frst   = 1'b1;
      r_d.cfault = 1'b0;
    end
    // Watchdog on bit 11 toggling
    if (watchdog_delay_setting == 8'h00 || !r_q.active) begin
      r_d.unit_cnt = '0;
      r_d.wd_units = '0;
      r_d.cfault   = 1'b0;
    end else if (wd_edge) begin
      r_d.unit_cnt = '0;
      r_d.wd_units = '0;
    end else if (r_q.unit_cnt == 23'(`FBCW_WD_UNIT_CYCLES - 1)) begin
      r_d.unit_cnt = '0;
      if (r_q.wd_units + 8'h01 >= watchdog_delay_setting) begin
        r_d.cfault = 1'b1;
      end else begin
        r_d.wd_units = r_q.wd_units + 8'h01;
      end
    end else begin
      r_d.unit_cnt = r_q.unit_cnt + 23'h000001;
    end
    // Command decoding
    r_d.run   = 1'b0;
    r_d.coast = 1'b0;
    r_d.qstop = 1'b0;
    r_d.rout0 = 1'b0;
    r_d.rhold = 1'b0;
    r_d.rin0  = 1'b0;
    r_d.inch1 = 1'b0;
    r_d.inch2 = 1'b0;
    if (r_d.active) begin
      if (comb == fbcw_pkg::COMB_PROFILE) begin
        // Bits 12 to 15 are not decoded
        r_d.run   = cw[`FBCW_CB_RUN] && r_q.st == fbcw_pkg::ST_RUN;
        r_d.coast = !cw[`FBCW_CB_COAST_N];
        r_d.qstop = !cw[`FBCW_CB_QSTOP_N];
        r_d.rout0 = !cw[`FBCW_CB_RAMP_OUT];
        r_d.rhold = cw[`FBCW_CB_RAMP_OUT] && !cw[`FBCW_CB_RAMP_HOLD_N];
        r_d.rin0  = cw[`FBCW_CB_RAMP_OUT] && cw[`FBCW_CB_RAMP_HOLD_N] &&
                    !cw[`FBCW_CB_RAMP_IN];
        r_d.inch1 = cw[`FBCW_CB_INCH1];
        r_d.inch2 = cw[`FBCW_CB_INCH2];
      end else if (comb != fbcw_pkg::COMB_REFUSED) begin
        r_d.run = cw[`FBCW_CB_RUN];
      end
    end
    // Profile state machine
    case (r_q.st)
      fbcw_pkg::ST_INHIBIT: begin
        if (cw[`FBCW_CB_ON] && !cw_prev[`FBCW_CB_ON] &&
            cw[`FBCW_CB_COAST_N] && cw[`FBCW_CB_QSTOP_N]) begin
          r_d.st = fbcw_pkg::ST_READY;
        end
      end
      fbcw_pkg::ST_READY: begin
        if (cw[`FBCW_CB_ON] && df[2]) begin
          r_d.st = fbcw_pkg::ST_OPERATE;
        end
      end
      fbcw_pkg::ST_OPERATE: begin
        if (cw[`FBCW_CB_RUN]) begin
          r_d.st = fbcw_pkg::ST_RUN;
        end else if (!cw[`FBCW_CB_ON]) begin
          r_d.st = fbcw_pkg::ST_READY;
        end
      end
      fbcw_pkg::ST_RUN: begin
        if (!cw[`FBCW_CB_RUN]) begin
          r_d.st = fbcw_pkg::ST_OPERATE;
        end
      end
      fbcw_pkg::ST_FAULT: begin
        if (r_d.frst) begin
          r_d.st = fbcw_pkg::ST_INHIBIT;
        end
      end
      default: begin
        r_d.st = fbcw_pkg::ST_INHIBIT;
      end
    endcase
    if (df[5] || r_q.cfault) begin
      if (r_q.st != fbcw_pkg::ST_FAULT && !r_d.frst) begin
        r_d.st = fbcw_pkg::ST_FAULT;
      end
    end else if (!cw[`FBCW_CB_COAST_N] || !cw[`FBCW_CB_QSTOP_N]) begin
      r_d.st = fbcw_pkg::ST_INHIBIT;
    end
    // Status word
    if (comb == fbcw_pkg::COMB_BASIC) begin
      r_d.status = 16'h0000;
      r_d.status[`FBCW_SB_READY_ON]   = sm[0];
      r_d.status[`FBCW_SB_READY_OP]   = sm[1];
      r_d.status[`FBCW_SB_RUNNING]    = sm[2];
      r_d.status[`FBCW_SB_NO_COAST]   = sm[4];
      r_d.status[`FBCW_SB_NO_QSTOP]   = sm[5];
      r_d.status[`FBCW_SB_INHIBIT]    = sm[6];
      r_d.status[`FBCW_SB_BUS_ACTIVE] = sm[9];
      r_d.status[`FBCW_SB_FAULT]      = df[5];
      r_d.status[`FBCW_SB_WARNING]    = df[4];
      r_d.status[`FBCW_SB_DRV_RUN]    = df[3];
      r_d.status[`FBCW_SB_DRV_READY]  = df[2];
      r_d.status[`FBCW_SB_AT_REF]     = df[1];
    end else if (comb == fbcw_pkg::COMB_REFUSED) begin
      r_d.status = 16'h0000;
    end else begin
      case (profile_status_word_param)
        `FBCW_STATUS_SEL_RAW:  r_d.status = cw;
        `FBCW_STATUS_SEL_ZERO: r_d.status = 16'h0000;
        default:               r_d.status = prof_status;
      endcase
    end
  end

  // ==========================================================
  // Profile status word
  always_comb begin
    prof_status = 16'h0000;
    prof_status[`FBCW_SB_READY_ON]   = r_q.st != fbcw_pkg::ST_INHIBIT &&
                                       r_q.st != fbcw_pkg::ST_FAULT;
    prof_status[`FBCW_SB_READY_OP]   = r_q.st == fbcw_pkg::ST_OPERATE ||
                                       r_q.st == fbcw_pkg::ST_RUN;
    prof_status[`FBCW_SB_RUNNING]    = r_q.st == fbcw_pkg::ST_RUN && df[3];
    prof_status[`FBCW_SB_FAULT]      = df[5] || r_q.cfault;
    prof_status[`FBCW_SB_NO_COAST]   = cw[`FBCW_CB_COAST_N];
    prof_status[`FBCW_SB_NO_QSTOP]   = cw[`FBCW_CB_QSTOP_N];
    prof_status[`FBCW_SB_INHIBIT]    = r_q.st == fbcw_pkg::ST_INHIBIT;
    prof_status[`FBCW_SB_WARNING]    = df[4];
    prof_status[`FBCW_SB_AT_REF]     = df[1];
    prof_status[`FBCW_SB_BUS_ACTIVE] = r_q.active;
    prof_status[`FBCW_SB_ABOVE_LIM]  = df[0];
    prof_status[`FBCW_SB_WD_ECHO]    = cw[`FBCW_CB_WDOG];
  end

  // ==========================================================
  // Register
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      r_q         <= '0;
      r_q.st      <= fbcw_pkg::ST_INHIBIT;
      r_q.status  <= `FBCW_WORD_RESET;
      r_q.bw_prev <= `FBCW_WORD_RESET;
      r_q.pw_prev <= `FBCW_WORD_RESET;
    end else begin
      r_q <= r_d;
    end
  end

  // ==========================================================
  // Outputs
  assign basic_bus_status_word = r_q.status;
  assign bus_refused           = r_q.refused;
  assign bus_ctrl_active       = r_q.active;
  assign run_cmd               = r_q.run;
  assign coast_stop            = r_q.coast;
  assign quick_stop            = r_q.qstop;
  assign ramp_out_zero         = r_q.rout0;
  assign ramp_hold             = r_q.rhold;
  assign ramp_in_zero          = r_q.rin0;
  assign inch1_cmd             = r_q.inch1;
  assign inch2_cmd             = r_q.inch2;
  assign fault_reset           = r_q.frst;
  assign comm_fault            = r_q.cfault;
  assign three_bit_mode        = r_q.three;

endmodule : fbcw_interp

// ### testbench/fbcw_interp_checker.sv
/*
  Concurrent checks on the ports of the control word interpreter.
  Assumes a bind to fbcw_interp and fbcw_defs.svh on the include path.
*/
`timescale 1ns/1ps
`include "fbcw_defs.svh"

module fbcw_interp_checker (
  // Clock and reset
  input wire logic        core_clk,
  input wire logic        rstn,
  // Configuration
  input wire logic [1:0]  bus_board_operate_mode,
  input wire logic [1:0]  drive_state_machine_select,
  input wire logic [1:0]  control_place_select,
  input wire logic [1:0]  profile_status_word_param,
  input wire logic [7:0]  watchdog_delay_setting,
  // Bus words
  input wire logic [15:0] basic_bus_command_word,
  input wire logic [15:0] profile_bus_command_word,
  input wire logic [10:0] bus_board_state_machine,
  // Drive flags
  input wire logic        drv_fault,
  input wire logic        drv_warning,
  input wire logic        drv_running,
  input wire logic        drv_ready,
  input wire logic        drv_at_ref,
  input wire logic        drv_above_limit,
  // Watched outputs
  input wire logic [15:0] basic_bus_status_word,
  input wire logic        bus_refused,
  input wire logic        bus_ctrl_active,
  input wire logic        run_cmd,
  input wire logic        coast_stop,
  input wire logic        quick_stop,
  input wire logic        ramp_out_zero,
  input wire logic        ramp_hold,
  input wire logic        ramp_in_zero,
  input wire logic        inch1_cmd,
  input wire logic        inch2_cmd,
  input wire logic        fault_reset,
  input wire logic        comm_fault,
  input wire logic        three_bit_mode
);
  // ==========================================================
  // Checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);

  refused_comb_a: assert property (
    (bus_board_operate_mode == `FBCW_MODE_PROFILE &&
     drive_state_machine_select == `FBCW_SM_PROFILE) [*4] |-> bus_refused)
    else $error("refusal missing");
  refused_quiet_a: assert property (
    bus_refused [*3] |-> basic_bus_status_word == 16'h0000 && !run_cmd &&
    !fault_reset && !bus_ctrl_active) else $error("output while refused");
  three_bit_a: assert property (
    three_bit_mode |-> $past(bus_board_operate_mode) == `FBCW_MODE_BYPASS &&
    $past(drive_state_machine_select) == `FBCW_SM_BASIC) else $error("bad three bit mode");
  reset_pulse_a: assert property (
    fault_reset |=> !fault_reset) else $error("fault reset too long");
  at_ref_a: assert property (
    (bus_board_operate_mode == `FBCW_MODE_PROFILE && $stable(drv_at_ref) &&
     drive_state_machine_select == `FBCW_SM_BASIC) [*7] |->
    basic_bus_status_word[8] == drv_at_ref) else $error("at reference bit wrong");
  ramp_prio_a: assert property (
    ramp_out_zero |-> !ramp_hold && !ramp_in_zero) else $error("ramp priority broken");
  bus_place_a: assert property (
    bus_ctrl_active |-> $past(control_place_select) == `FBCW_PLACE_FIELDBUS)
    else $error("bus control without place");
  wd_off_a: assert property (
    (watchdog_delay_setting == 8'h00) [*3] |-> !comm_fault) else $error("watchdog while off");
  inch_gate_a: assert property (
    inch1_cmd || inch2_cmd |-> bus_ctrl_active && !bus_refused) else $error("inching ungated");
endmodule : fbcw_interp_checker

// ### testbench/fbcw_plc_model.sv
/*
  Bus master model: holds the two command words and toggles the watchdog bit.
  Assumes the bench stages words through set_words on the core clock.
*/
`timescale 1ns/1ps

module fbcw_plc_model #(
  parameter int WD_HALF = 20
) (
  // Clock and watchdog enable
  input  wire logic        core_clk,
  input  wire logic        wd_en,
  // Command words
  output logic      [15:0] basic_bus_command_word,
  output logic      [15:0] profile_bus_command_word
);
  // ==========================================================
  // Word staging
  logic [15:0] bw_s   = 16'h0000;
  logic [15:0] pw_s   = 16'h0000;
  logic        wd_q   = 1'b0;
  int          wd_cnt = 0;

  task automatic set_words(input logic [15:0] b, input logic [15:0] p);
    @(posedge core_clk);
    bw_s <= b; // Run on bit 3, fault reset as a rising bit 7
    pw_s <= p;
  endtask : set_words

  // ==========================================================
  // Watchdog square wave on bit 11
  always @(posedge core_clk) begin
    wd_cnt <= (wd_cnt == WD_HALF - 1) ? 0 : wd_cnt + 1;
    if (wd_cnt == WD_HALF - 1) begin
      wd_q <= ~wd_q;
    end
  end
  assign basic_bus_command_word   = bw_s;
  assign profile_bus_command_word = wd_en ? {pw_s[15:12], wd_q, pw_s[10:0]} : pw_s;
endmodule : fbcw_plc_model

// ### testbench/fbcw_interp_tb_top.sv
/*
  Self-checking bench for the control word interpreter.
  Assumes fbcw_defs.svh on the include path and the master model beside it.
*/
`timescale 1ns/1ps
`include "fbcw_defs.svh"

module fbcw_interp_tb_top;
  // ==========================================================
  // Signals
  logic        core_clk = 1'b0;
  logic        rstn = 1'b0;
  logic [1:0]  bus_board_operate_mode = 2'h1;
  logic [1:0]  drive_state_machine_select = 2'h1;
  logic [1:0]  control_place_select = 2'h3;
  logic [1:0]  profile_status_word_param = 2'h0;
  logic [7:0]  watchdog_delay_setting = 8'h00;
  logic [10:0] bus_board_state_machine = 11'h000;
  logic        drv_fault = 1'b0, drv_warning = 1'b0, drv_running = 1'b0;
  logic        drv_ready = 1'b0, drv_at_ref = 1'b0, drv_above_limit = 1'b0;
  logic        wd_en = 1'b0;
  logic [15:0] bw, pw, w;
  logic        prev7 = 1'b0;
  logic [3:0]  prev_key = 4'h5;
  logic [59:0] exp_q[$];
  int          err_total = 0, num_checks = 0, fr_tot = 0, fr_base = 0, cyc = 0;
  int          seed = 77195;
  event        chk_ev;
  wire  [15:0] basic_bus_command_word, profile_bus_command_word, basic_bus_status_word;
  wire         bus_refused, bus_ctrl_active, run_cmd, coast_stop, quick_stop;
  wire         ramp_out_zero, ramp_hold, ramp_in_zero, inch1_cmd, inch2_cmd;
  wire         fault_reset, comm_fault, three_bit_mode;

  fbcw_interp DUT (.core_clk, .rstn, .bus_board_operate_mode, .drive_state_machine_select,
    .control_place_select, .profile_status_word_param, .watchdog_delay_setting,
    .basic_bus_command_word, .profile_bus_command_word, .bus_board_state_machine,
    .drv_fault, .drv_warning, .drv_running, .drv_ready, .drv_at_ref, .drv_above_limit,
    .basic_bus_status_word, .bus_refused, .bus_ctrl_active, .run_cmd, .coast_stop,
    .quick_stop, .ramp_out_zero, .ramp_hold, .ramp_in_zero, .inch1_cmd, .inch2_cmd,
    .fault_reset, .comm_fault, .three_bit_mode);
  fbcw_plc_model #(.WD_HALF(20)) PLC (.core_clk, .wd_en, .basic_bus_command_word,
    .profile_bus_command_word);

  // ==========================================================
  // Clock, timeout, pulse count
  always #12.5 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cyc++;
    if (fault_reset === 1'b1) fr_tot++;
    if (cyc == 5000) begin
      err_total++;
      report_and_stop();
    end
  end

  // ==========================================================
  // Tasks
  task automatic chk_eq(input string nm, input logic [29:0] seen, input logic [29:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk_eq

  task automatic report_and_stop();
    if (err_total == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : report_and_stop

  // Expected outputs {mask, value}; rx[1] asks for a run check of value rx[0]
  function automatic logic [59:0] expect_fn(input logic [1:0] rx);
    logic [29:0] e, k;
    logic        act, rf, pb;
    logic [3:0]  key;
    key = {bus_board_operate_mode, drive_state_machine_select};
    rf = (key == {`FBCW_MODE_PROFILE, `FBCW_SM_PROFILE});
    pb = (bus_board_operate_mode == `FBCW_MODE_BYPASS);
    w = pb ? pw : bw;
    act = w[10] && control_place_select == `FBCW_PLACE_FIELDBUS && !rf;
    e = '0;
    k = 30'h3FFFFFFF;
    e[11] = rf;
    e[10] = act;
    e[29:28] = {1'b0, !prev7 && w[7] && !rf};
    if (key != prev_key) k[29:28] = 2'b00;
    if (rf) begin
    end else if (pb && drive_state_machine_select == `FBCW_SM_BASIC) begin
      e[0] = 1'b1;
      k = 30'h00000801;
    end else if (pb) begin
      e[8:2] = {act & ~w[1], act & ~w[2], act & ~w[4], act & w[4] & ~w[5],
                act & w[4] & w[5] & ~w[6], act & w[8], act & w[9]};
      k[9] = 1'b0;
      if (profile_status_word_param == `FBCW_STATUS_SEL_RAW) e[27:12] = w;
      else if (profile_status_word_param != `FBCW_STATUS_SEL_ZERO) k[27:12] = '0;
    end else begin
      e[9] = act & w[3];
      e[27:12] = {2'b00, drv_ready, drv_running, 2'b00, bus_board_state_machine[9], drv_at_ref,
                  drv_warning, bus_board_state_machine[6:4], drv_fault,
                  bus_board_state_machine[2:0]};
    end
    if (rx[1]) begin
      k[9] = 1'b1;
      e[9] = rx[0];
    end
    prev7 = w[7];
    prev_key = key;
    return {k, e & k};
  endfunction : expect_fn

  task automatic apply(input logic [3:0] key, input logic [1:0] pr, input logic [15:0] b,
                       input logic [15:0] p, input logic [1:0] rx);
    {bus_board_operate_mode, drive_state_machine_select} <= key;
    profile_status_word_param <= pr;
    wd_en <= (pr != `FBCW_STATUS_SEL_RAW);
    bw = b;
    pw = {p[15:12], 1'b0, p[10:0]};
    PLC.set_words(b, pw);
    repeat (12) @(posedge core_clk);
    exp_q.push_back(expect_fn(rx));
    -> chk_ev;
  endtask : apply

  // ==========================================================
  // Monitor
  initial begin
    logic [59:0] e;
    forever begin
      @(chk_ev);
      #1;
      e = exp_q.pop_front();
      chk_eq("outputs", {fr_tot[1:0] - fr_base[1:0], basic_bus_status_word, bus_refused,
        bus_ctrl_active, run_cmd, coast_stop, quick_stop, ramp_out_zero, ramp_hold,
        ramp_in_zero, inch1_cmd, inch2_cmd, comm_fault, three_bit_mode} & e[59:30],
        e[29:0]);
      fr_base = fr_tot;
    end
  end

  // ==========================================================
  // Main sequence
  initial begin
    repeat (8) @(posedge core_clk);
    rstn <= 1'b1;
    drv_ready <= 1'b1;
    apply(4'hA, 2'h0, 16'h0000, 16'h047E, 2'b10);
    apply(4'hA, 2'h0, 16'h0000, 16'h047F, 2'b11);
    apply(4'hA, 2'h0, 16'h0000, 16'h047D, 2'b10);
    apply(4'hA, 2'h0, 16'h0000, 16'h047F, 2'b10); // No restart without a fresh rise
    apply(4'hA, 2'h0, 16'h0000, 16'h047E, 2'b10);
    apply(4'hA, 2'h0, 16'h0000, 16'h047F, 2'b11);
    apply(4'h5, 2'h0, 16'h0408, 16'h0000, 2'b00);
    apply(4'h5, 2'h0, 16'h0488, 16'h0000, 2'b00);
    apply(4'h6, 2'h0, 16'h0000, 16'h0000, 2'b00);
    apply(4'h6, 2'h0, 16'h0000, 16'h0480, 2'b00);
    for (int i = 0; i < 40; i++) begin
      control_place_select <= 2'($random(seed));
      watchdog_delay_setting <= 8'($random(seed));
      bus_board_state_machine <= 11'($random(seed));
      {drv_fault, drv_warning, drv_running, drv_ready, drv_at_ref, drv_above_limit}
        <= 6'($random(seed));
      apply({2'h1 + 2'(i[1] ^ i[4]), 2'h1 + 2'(i[0])}, 2'($unsigned($random(seed)) % 3),
            16'($random(seed)), 16'($random(seed)), 2'b00);
    end
    @(posedge core_clk);
    report_and_stop();
  end
endmodule : fbcw_interp_tb_top

bind fbcw_interp fbcw_interp_checker CHK (.core_clk, .rstn, .bus_board_operate_mode,
  .drive_state_machine_select, .control_place_select, .profile_status_word_param,
  .watchdog_delay_setting, .basic_bus_command_word, .profile_bus_command_word,
  .bus_board_state_machine, .drv_fault, .drv_warning, .drv_running, .drv_ready,
  .drv_at_ref, .drv_above_limit, .basic_bus_status_word, .bus_refused, .bus_ctrl_active,
  .run_cmd, .coast_stop, .quick_stop, .ramp_out_zero, .ramp_hold, .ramp_in_zero,
  .inch1_cmd, .inch2_cmd, .fault_reset, .comm_fault, .three_bit_mode);
